// File: hdl/nvpec_top.sv
// Program/erase sequencing and interlocks for the byte-addressed, 16-bit-read nonvolatile array
// Operation
// R01 - Guard refuses bulk/row erase; write-gated
// R02 - Size and row bits choose erase extent
// R03 - Size and row ignored without erase
// R04 - Single erase hits only latched location
// R05 - Erase bit selects erase versus program
// R06 - Control bits frozen while voltage applied
// R07 - Latch arm captures next array write
// R08 - Array unreadable while latch armed
// R09 - Control bits writable together or separately
// R10 - Voltage bit sets only when armed
// R11 - Arm plus voltage together: arm only
// R12 - Voltage follows the voltage bit
// R13 - Array writes ignored, latches held under voltage
// R14 - Host clears voltage, then arm
// R15 - Host follows arm, write, apply order
// R16 - Host times program and erase delays
// R17 - Host may loop back keeping arm
// R18 - Pump monitor routes pump to pin
// R19 - Guard lock once normal, free special
// R20 - Misaligned word latches lower byte only
// R21 - Stop removes voltage, keeps bit
// R22 - Reset reads guard set, others zero
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module nvpec_top (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [nvpec_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic pready_o,
    output logic [31:0] prdata_o,
    output logic pslverr_o,
    input wire logic special_mode_n_i,
    input wire logic stop_mode_i,
    input wire logic arr_wr_i,
    input wire logic arr_rd_i,
    input wire logic [nvpec_pkg::ADDR_W-1:0] arr_addr_i,
    input wire logic [15:0] arr_wdata_i,
    input wire logic arr_word_i,
    input wire logic [15:0] mem_rdata_i,
    output logic [15:0] arr_rdata_o,
    output logic arr_rvalid_o,
    output logic [nvpec_pkg::ADDR_W-1:0] lat_addr_o,
    output logic [15:0] lat_data_o,
    output logic lat_word_o,
    output logic erase_mode_o,
    output nvpec_pkg::nvpec_size_type erase_size_o,
    output logic erase_refused_o,
    output logic hv_on_o,
    output logic pump_monitor_o
);
    import nvpec_pkg::*;
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    // ****************************************
    // Register bus
    // ****************************************
    logic ctrl_wr;
    logic aux_wr;
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic [7:0] aux_q;
    logic [7:0] aux_d;
    logic lock_once_q;
    wire [7:0] wd = pwdata_i[7:0];

    nvpec_apb u_apb (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .psel_i(psel_i),
        .penable_i(penable_i),
        .pwrite_i(pwrite_i),
        .paddr_i(paddr_i),
        .ctrl_rd_i(ctrl_q),
        .aux_rd_i(aux_q),
        .ctrl_wr_o(ctrl_wr),
        .aux_wr_o(aux_wr),
        .pready_o(pready_o),
        .prdata_o(prdata_o),
        .pslverr_o(pslverr_o)
    );

    a_ctrl_read: assert property (psel_i && !penable_i && !pwrite_i // R22
        && idx_hit(paddr_i, CTRL_IDX) |=> prdata_o == {24'h00_0000, $past(ctrl_q)})
        else $error("control read returned wrong value");

    // ****************************************
    // Mode strap synchroniser
    // ****************************************
    logic smn_s1_q;
    logic smn_s2_q;
    logic smn_s3_q;
    logic normal_q;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            smn_s1_q <= 1'b1;
            smn_s2_q <= 1'b1;
            smn_s3_q <= 1'b1;
            normal_q <= 1'b1;
        end else begin
            smn_s1_q <= special_mode_n_i;
            smn_s2_q <= smn_s1_q;
            smn_s3_q <= smn_s2_q;
            // A bouncing strap cannot flip the mode until two stages agree
            if (smn_s2_q == smn_s3_q) begin
                normal_q <= smn_s3_q;
            end
        end
    end

    a_mode_filtered: assert property (smn_s2_q != smn_s3_q // R19
        |=> normal_q == $past(normal_q))
        else $error("mode followed an unsettled strap");

    // ****************************************
    // Control register next state
    // ****************************************
    wire guard = ctrl_q[GUARD_BIT];
    wire size_sel = ctrl_q[SIZE_BIT];
    wire row_sel = ctrl_q[ROW_BIT];
    wire erase = ctrl_q[ERASE_BIT];
    wire latch_arm = ctrl_q[LATCH_BIT];
    wire hv = ctrl_q[HV_BIT];
    wire guard_lock = aux_q[LOCK_BIT];
    wire cfg_wr = ctrl_wr & ~hv; // R06 R09
    wire guard_wr = cfg_wr & ~guard_lock; // R01

    always_comb begin
        ctrl_d = ctrl_q;
        ctrl_d[6:5] = 2'b00; // R22
        if (guard_wr) begin
            ctrl_d[GUARD_BIT] = wd[GUARD_BIT];
        end
        if (cfg_wr) begin
            ctrl_d[SIZE_BIT] = wd[SIZE_BIT];
            ctrl_d[ROW_BIT] = wd[ROW_BIT];
            ctrl_d[ERASE_BIT] = wd[ERASE_BIT];
            ctrl_d[LATCH_BIT] = wd[LATCH_BIT]; // R07
        end
        if (ctrl_wr) begin
            // Every control write rewrites the voltage bit, so clearing is never refused
            ctrl_d[HV_BIT] = wd[HV_BIT] & latch_arm; // R10 R11
        end
    end

    a_guard_frozen: assert property (hv |=> $stable(guard)) // R01
        else $error("guard changed under voltage");
    a_guard_written: assert property (guard_wr |=> guard == $past(wd[GUARD_BIT])) // R01
        else $error("guard write not taken");
    a_cfg_written: assert property (cfg_wr // R09
        |=> ctrl_q[SIZE_BIT:LATCH_BIT] == $past(wd[SIZE_BIT:LATCH_BIT]))
        else $error("config write not taken");
    a_hv_needs_write: assert property (!ctrl_wr |=> $stable(hv)) // R12
        else $error("voltage bit moved without a write");
    a_hv_clear_ok: assert property (ctrl_wr && !wd[HV_BIT] |=> !hv) // R12
        else $error("voltage bit did not clear");

    // ****************************************
    // Auxiliary register: guard lock and pump monitor
    // ****************************************
    wire lock_wr = aux_wr & (~normal_q | ~lock_once_q); // R19

    always_comb begin
        aux_d = aux_q;
        aux_d[7:2] = 6'h00;
        if (lock_wr) begin
            aux_d[LOCK_BIT] = wd[LOCK_BIT];
        end
        if (aux_wr & ~normal_q) begin
            aux_d[PUMP_BIT] = wd[PUMP_BIT];
        end
        if (normal_q) begin
            aux_d[PUMP_BIT] = 1'b0;
        end
    end

    a_lock_once: assert property (normal_q && lock_once_q && aux_wr // R19
        |=> $stable(guard_lock))
        else $error("guard lock rewritten in normal mode");
    a_lock_special: assert property (!normal_q && aux_wr // R19
        |=> guard_lock == $past(wd[LOCK_BIT]))
        else $error("guard lock write refused in special mode");
    a_pump_normal: assert property (normal_q |=> !pump_monitor_o) // R18
        else $error("pump monitor on in normal mode");
    a_aux_unused: assert property (aux_wr |=> aux_q[7:2] == 6'h00) // R22
        else $error("unused auxiliary bits nonzero");

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_q <= CTRL_RESET; // R22
            aux_q <= AUX_RESET;
            lock_once_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            aux_q <= aux_d;
            lock_once_q <= lock_once_q | (aux_wr & normal_q);
        end
    end

    // ****************************************
    // Target latches
    // ****************************************
    wire capture = arr_wr_i & latch_arm & ~hv; // R07 R13

    nvpec_latch u_latch (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .capture_i(capture),
        .addr_i(arr_addr_i),
        .wdata_i(arr_wdata_i),
        .word_i(arr_word_i),
        .addr_o(lat_addr_o),
        .data_o(lat_data_o),
        .word_o(lat_word_o)
    );

    a_capture_gated: assert property ($changed(lat_addr_o) // R07 R13
        |-> $past(latch_arm) && !$past(hv))
        else $error("latch moved without an armed write");
    a_latch_data: assert property (capture |=> lat_addr_o == $past(arr_addr_i)) // R07
        else $error("latched address is not the written one");
    a_arm_clear_frees: assert property (!latch_arm && arr_wr_i // R07
        |=> $stable(lat_addr_o) && $stable(lat_data_o))
        else $error("unarmed write reached the latches");
    a_odd_byte: assert property (lat_addr_o[0] |-> !lat_word_o) // R20
        else $error("word latched at an odd address");

    // ****************************************
    // Erase selection and voltage control
    // ****************************************
    nvpec_size_type size_sel_d;
    assign size_sel_d = size_sel ? SZ_LOC : (row_sel ? SZ_ROW : SZ_ARRAY); // R02 R04
    assign erase_size_o = erase ? size_sel_d : SZ_LOC; // R03
    assign erase_mode_o = erase; // R05
    assign erase_refused_o = erase & guard & ~size_sel; // R01
    // Stop drops the voltage but keeps the bit, so leaving stop resumes the operation
    assign hv_on_o = hv & ~stop_mode_i & ~erase_refused_o; // R12 R21
    assign pump_monitor_o = aux_q[PUMP_BIT]; // R18

    a_size_idle: assert property (!erase |-> erase_size_o == SZ_LOC) // R03
        else $error("size shown outside erase");
    a_row_size: assert property (erase && !size_sel && row_sel // R02
        |-> erase_size_o == SZ_ROW)
        else $error("row erase not selected");
    a_stop_no_hv: assert property (stop_mode_i |-> !hv_on_o) // R21
        else $error("voltage applied in stop");
    a_hv_off_clear: assert property (!hv |-> !hv_on_o) // R12
        else $error("voltage without the voltage bit");

    // ****************************************
    // Array read path
    // ****************************************
    logic [15:0] rdata_q;
    logic rvalid_q;
    wire rd_ok = arr_rd_i & ~latch_arm; // R08

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= 16'h0000;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= rd_ok ? mem_rdata_i : 16'h0000;
            rvalid_q <= rd_ok;
        end
    end

    assign arr_rdata_o = rdata_q;
    assign arr_rvalid_o = rvalid_q;

    a_read_served: assert property (arr_rd_i && !latch_arm |=> arr_rvalid_o // R08
        && arr_rdata_o == $past(mem_rdata_i))
        else $error("unarmed array read not served");

    // ****************************************
    // Checks
    // ****************************************
    a_hv_needs_arm: assert property ($rose(hv) |-> $past(latch_arm)) // R10
        else $error("voltage bit set without latch arm");
    a_arm_wins: assert property (ctrl_wr && !latch_arm && wd[1:0] == 2'b11 // R11
        |=> latch_arm && !hv)
        else $error("arm and voltage together did not leave voltage clear");
    a_cfg_frozen: assert property (hv |=> $stable(ctrl_q[SIZE_BIT:LATCH_BIT])) // R06
        else $error("config bits changed under voltage");
    a_guard_locked: assert property (guard_lock |=> $stable(guard)) // R01
        else $error("guard changed while locked");
    a_bulk_refused: assert property (guard && erase && !size_sel |-> !hv_on_o) // R01
        else $error("bulk or row erase voltage under guard");
    a_stop_keeps: assert property (hv && stop_mode_i && !ctrl_wr |=> hv) // R21
        else $error("stop cleared the voltage bit");
    a_read_blocked: assert property (latch_arm && arr_rd_i |=> !arr_rvalid_o) // R08
        else $error("array read returned while armed");
    a_latch_held: assert property (hv |=> $stable(lat_addr_o) && $stable(lat_data_o)) // R13
        else $error("latches changed under voltage");
    a_unused_zero: assert property (ctrl_wr |=> ctrl_q[6:5] == 2'b00) // R22
        else $error("unused control bits nonzero");
endmodule : nvpec_top
`default_nettype wire

// File: pkg/nvpec_pkg.sv
// Constants and types for the nonvolatile program/erase controller
`default_nettype none
package nvpec_pkg;
    // ****************************************
    // Register map (index, byte address = 4 * index)
    // ****************************************
    localparam int ADDR_W = 12;
    localparam logic [9:0] CTRL_IDX = 10'h0f3;
    localparam logic [9:0] AUX_IDX = 10'h0f4;
    localparam logic [7:0] CTRL_RESET = 8'h80;
    localparam logic [7:0] AUX_RESET = 8'h00;
    // ****************************************
    // Control and auxiliary field positions
    // ****************************************
    localparam int GUARD_BIT = 7;
    localparam int SIZE_BIT = 4;
    localparam int ROW_BIT = 3;
    localparam int ERASE_BIT = 2;
    localparam int LATCH_BIT = 1;
    localparam int HV_BIT = 0;
    localparam int LOCK_BIT = 0;
    localparam int PUMP_BIT = 1;
    localparam int ROW_BYTES = 32;
    // Host-side wait while voltage is applied; the block never times it
    localparam int PROGRAM_DELAY_CYCLES = 20;
    // ****************************************
    // Types and helpers
    // ****************************************
    typedef enum logic [1:0] {
        SZ_ARRAY,
        SZ_ROW,
        SZ_LOC
    } nvpec_size_type;

    function automatic logic idx_hit(input logic [ADDR_W-1:0] addr, input logic [9:0] idx);
        idx_hit = (addr == {idx, 2'b00});
    endfunction : idx_hit
endpackage : nvpec_pkg
`default_nettype wire

// File: hdl/nvpec_apb.sv
// APB slave front end for the program/erase controller registers
`timescale 1ns/1ps
`default_nettype none
module nvpec_apb (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [nvpec_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [7:0] ctrl_rd_i,
    input wire logic [7:0] aux_rd_i,
    output logic ctrl_wr_o,
    output logic aux_wr_o,
    output logic pready_o,
    output logic [31:0] prdata_o,
    output logic pslverr_o
);
    import nvpec_pkg::*;
    logic [31:0] prdata_q;
    logic err_q;
    wire hit_ctrl = idx_hit(paddr_i, CTRL_IDX);
    wire hit_aux = idx_hit(paddr_i, AUX_IDX);
    wire setup = psel_i & ~penable_i;
    wire access = psel_i & penable_i & pwrite_i;
    wire [7:0] rd_mux = hit_ctrl ? ctrl_rd_i : (hit_aux ? aux_rd_i : 8'h00);

    // Read data and error are captured in the setup cycle
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            prdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
        end else if (setup) begin
            prdata_q <= pwrite_i ? 32'h0000_0000 : {24'h00_0000, rd_mux};
            err_q <= ~(hit_ctrl | hit_aux);
        end
    end

    assign pready_o = psel_i & penable_i;
    assign prdata_o = prdata_q;
    assign pslverr_o = err_q;
    assign ctrl_wr_o = access & hit_ctrl;
    assign aux_wr_o = access & hit_aux;
endmodule : nvpec_apb
`default_nettype wire

// File: hdl/nvpec_latch.sv
// Address and data latches for the program/erase target
`timescale 1ns/1ps
`default_nettype none
module nvpec_latch (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic capture_i,
    input wire logic [nvpec_pkg::ADDR_W-1:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic word_i,
    output logic [nvpec_pkg::ADDR_W-1:0] addr_o,
    output logic [15:0] data_o,
    output logic word_o
);
    import nvpec_pkg::*;
    logic [ADDR_W-1:0] addr_q;
    logic [15:0] data_q;
    logic word_q;
    wire misaligned = word_i & addr_i[0];
    wire [15:0] data_d = misaligned ? {8'h00, wdata_i[7:0]} : wdata_i;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            addr_q <= '0;
            data_q <= 16'h0000;
            word_q <= 1'b0;
        end else if (capture_i) begin
            addr_q <= addr_i;
            data_q <= data_d; // R20
            word_q <= word_i & ~misaligned; // R20
        end
    end

    assign addr_o = addr_q;
    assign data_o = data_q;
    assign word_o = word_q;
endmodule : nvpec_latch
`default_nettype wire

// File: tb/nvtb_mem_model.sv
// Behavioural array macro that answers the controller's read port
`timescale 1ns/1ps
`default_nettype none
module nvtb_mem_model (
    input wire logic arr_rd_i,
    input wire logic [nvpec_pkg::ADDR_W-1:0] arr_addr_i,
    output logic [15:0] mem_rdata_o
);
    import nvpec_pkg::*;
    // ****************************************
    // Read data
    // ****************************************
    // Off a read the lines show the inverse, so stale data never matches
    assign mem_rdata_o = arr_rd_i ? {4'h5, arr_addr_i} : ~{4'h5, arr_addr_i};
endmodule : nvtb_mem_model
`default_nettype wire

// File: tb/test_eeprom_program_erase_control.sv
// Self-checking bench for the program/erase controller
`timescale 1ns/1ps
`default_nettype none
module test_eeprom_program_erase_control;
    import nvpec_pkg::*;
    typedef struct packed {
        logic [7:0] wd;
        logic [1:0] sz;
        logic md;
        logic rf;
    } nvtb_row_type;
    localparam logic [11:0] CTRL_A = {CTRL_IDX, 2'b00};
    localparam logic [11:0] AUX_A = {AUX_IDX, 2'b00};
    logic ref_clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic [11:0] paddr_i = '0, arr_addr_i = '0;
    logic [31:0] pwdata_i = '0, prdata_o, rd;
    logic special_mode_n_i = 1, stop_mode_i = 0, arr_wr_i = 0, arr_rd_i = 0, arr_word_i = 0;
    logic [15:0] arr_wdata_i = '0, mem_rdata_i, arr_rdata_o, lat_data_o;
    logic [11:0] lat_addr_o;
    logic pready_o, pslverr_o, arr_rvalid_o, lat_word_o, erase_mode_o, err;
    logic erase_refused_o, hv_on_o, pump_monitor_o;
    nvpec_size_type erase_size_o;
    int errors = 0, compares = 0, cycles = 0;
    nvtb_row_type rows [8] = '{'{8'h04, SZ_ARRAY, 1'b1, 1'b0}, '{8'h0c, SZ_ROW, 1'b1, 1'b0},
        '{8'h1c, SZ_LOC, 1'b1, 1'b0}, '{8'h14, SZ_LOC, 1'b1, 1'b0},
        '{8'h18, SZ_LOC, 1'b0, 1'b0}, '{8'h84, SZ_ARRAY, 1'b1, 1'b1},
        '{8'h8c, SZ_ROW, 1'b1, 1'b1}, '{8'h94, SZ_LOC, 1'b1, 1'b0}};
    nvpec_top u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
        .special_mode_n_i(special_mode_n_i), .stop_mode_i(stop_mode_i), .arr_wr_i(arr_wr_i),
        .arr_rd_i(arr_rd_i), .arr_addr_i(arr_addr_i), .arr_wdata_i(arr_wdata_i),
        .arr_word_i(arr_word_i), .mem_rdata_i(mem_rdata_i), .arr_rdata_o(arr_rdata_o),
        .arr_rvalid_o(arr_rvalid_o), .lat_addr_o(lat_addr_o), .lat_data_o(lat_data_o),
        .lat_word_o(lat_word_o), .erase_mode_o(erase_mode_o), .erase_size_o(erase_size_o),
        .erase_refused_o(erase_refused_o), .hv_on_o(hv_on_o), .pump_monitor_o(pump_monitor_o));
    nvtb_mem_model u_mem (.arr_rd_i(arr_rd_i), .arr_addr_i(arr_addr_i), .mem_rdata_o(mem_rdata_i));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= {24'h0, d};
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        do @(posedge ref_clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb
    task automatic ctrl(input logic [7:0] d, input logic [7:0] exp);
        apb(1'b1, CTRL_A, d);
        apb(1'b0, CTRL_A, 8'h00);
        chk("ctrl", rd, {24'h0, exp});
    endtask : ctrl
    task automatic arr(input logic w, input logic [11:0] a, input logic [15:0] d, input logic wd);
        @(posedge ref_clk_i);
        arr_wr_i <= w;
        arr_rd_i <= !w;
        arr_addr_i <= a;
        arr_wdata_i <= d;
        arr_word_i <= wd;
        @(posedge ref_clk_i);
        arr_wr_i <= 1'b0;
        arr_rd_i <= 1'b0;
        #1;
    endtask : arr
    task automatic finish_test;
        if (errors == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test
    // ****************************************
    // Clock, timeout and sequence
    // ****************************************
    initial begin
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            finish_test();
        end
    end
    initial begin
        repeat (6) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        apb(1'b0, CTRL_A, 8'h00);
        chk("ctrl_reset", rd, 32'h80);
        apb(1'b0, AUX_A, 8'h00);
        chk("aux_reset", rd, 32'h0);
        apb(1'b1, 12'h3d4, 8'hff);
        chk("unmapped_err", {31'h0, err}, 32'h1);
        foreach (rows[i]) begin
            ctrl(rows[i].wd, rows[i].wd);
            chk("size", {30'h0, erase_size_o}, {30'h0, rows[i].sz});
            chk("mode", {31'h0, erase_mode_o}, {31'h0, rows[i].md});
            chk("refused", {31'h0, erase_refused_o}, {31'h0, rows[i].rf});
        end
        ctrl(8'h03, 8'h02);
        arr(1'b1, 12'h010, 16'h1234, 1'b1);
        chk("lat", {lat_word_o, 3'h0, lat_addr_o, lat_data_o}, 32'h8010_1234);
        arr(1'b0, 12'h020, 16'h0000, 1'b0);
        chk("rvalid_armed", {31'h0, arr_rvalid_o}, 32'h0);
        ctrl(8'h03, 8'h03);
        chk("hv_on", {31'h0, hv_on_o}, 32'h1);
        arr(1'b1, 12'h030, 16'h5555, 1'b1);
        chk("lat_held", {lat_word_o, 3'h0, lat_addr_o, lat_data_o}, 32'h8010_1234);
        ctrl(8'h9f, 8'h03);
        @(posedge ref_clk_i);
        stop_mode_i <= 1'b1;
        @(posedge ref_clk_i);
        #1;
        chk("hv_stop", {31'h0, hv_on_o}, 32'h0);
        @(posedge ref_clk_i);
        stop_mode_i <= 1'b0;
        #1;
        chk("hv_resume", {31'h0, hv_on_o}, 32'h1);
        repeat (PROGRAM_DELAY_CYCLES) @(posedge ref_clk_i);
        chk("hv_held", {31'h0, hv_on_o}, 32'h1);
        ctrl(8'h02, 8'h02);
        chk("hv_off", {31'h0, hv_on_o}, 32'h0);
        arr(1'b1, 12'h011, 16'habcd, 1'b1);
        chk("lat_odd", {lat_word_o, 3'h0, lat_addr_o, lat_data_o}, 32'h0011_00cd);
        ctrl(8'h00, 8'h00);
        arr(1'b0, 12'h020, 16'h0000, 1'b0);
        chk("read", {15'h0, arr_rvalid_o, arr_rdata_o}, 32'h0001_5020);
        apb(1'b1, AUX_A, 8'h01);
        apb(1'b1, AUX_A, 8'h00);
        apb(1'b0, AUX_A, 8'h00);
        chk("lock_once", rd, 32'h1);
        ctrl(8'h80, 8'h00);
        special_mode_n_i <= 1'b0;
        repeat (6) @(posedge ref_clk_i);
        apb(1'b1, AUX_A, 8'h02);
        apb(1'b0, AUX_A, 8'h00);
        chk("aux_special", rd, 32'h2);
        chk("pump", {31'h0, pump_monitor_o}, 32'h1);
        rst_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        apb(1'b0, CTRL_A, 8'h00);
        chk("ctrl_rerun", rd, 32'h80);
        apb(1'b0, AUX_A, 8'h00);
        chk("aux_rerun", rd, 32'h0);
        chk("pump_rerun", {31'h0, pump_monitor_o}, 32'h0);
        finish_test();
    end
endmodule : test_eeprom_program_erase_control
`default_nettype wire
